// >>> hw/tcs_pkg.sv
// Package of constants and carrier types for the statistics counter and interrupt block.
package tcs_pkg;

  localparam int NUM_LINK = 16;
  localparam int NUM_CNT  = 144;
  localparam int CNT_W    = 24;
  localparam int LATCH_W  = 16;

  // Counter index map: four per input port, two per transmit link, three per receive link.
  localparam int IN_BASE = 0;
  localparam int IN_PER  = 4;
  localparam int TX_BASE = 64;
  localparam int TX_PER  = 2;
  localparam int RX_BASE = 96;
  localparam int RX_PER  = 3;

  // Register word addresses.
  localparam logic [10:0] ADDR_CMD      = 11'h40f;
  localparam logic [10:0] ADDR_OVF_BASE = 11'h410;
  localparam logic [10:0] ADDR_HOLD_UP  = 11'h430;
  localparam logic [10:0] ADDR_HOLD_LO  = 11'h431;
  localparam logic [10:0] ADDR_SEL      = 11'h432;
  localparam logic [10:0] ADDR_MEN      = 11'h433;
  localparam logic [10:0] ADDR_OVF_EN   = 11'h434;
  localparam logic [10:0] ADDR_LST_BASE = 11'h435;
  localparam logic [10:0] ADDR_LEN_BASE = 11'h445;
  localparam logic [10:0] ADDR_MST      = 11'h455;

  // Transfer command fields.
  localparam logic [2:0] OP_CONFIG    = 3'h0;
  localparam logic [2:0] OP_WRITE     = 3'h1;
  localparam logic [2:0] OP_IRQ       = 3'h2;
  localparam logic [2:0] OP_READ      = 3'h5;
  localparam int         CMD_IRQ_BIT   = 3;
  localparam int         CMD_TRIG_BIT  = 4;
  localparam int         CMD_DIV_BIT   = 5;
  localparam int         CMD_LATCH_BIT = 6;
  localparam int         CMD_READY_BIT = 7;

  // Link status and overflow status layouts.
  localparam int          LCD_ON_BIT        = 1;
  localparam int          LCD_OFF_BIT       = 9;
  localparam logic [15:0] LST_LATCH_MASK    = 16'h0e7e;
  localparam logic [15:0] OVF_USED_MASK     = 16'h1fae;

  localparam logic [23:0] CNT_MAX_FULL  = 24'hffffff;
  localparam logic [23:0] CNT_MAX_LATCH = 24'h00ffff;
  localparam int          FRAME_DIV     = 8000;

  typedef struct packed {
    logic [15:0] inCell;
    logic [15:0] inIdle;
    logic [15:0] inUnassigned;
    logic [15:0] inHecErr;
    logic [15:0] inHecFixed;
    logic [15:0] txCell;
    logic [15:0] txIdleUser;
    logic [15:0] rxCell;
    logic [15:0] rxIdleUser;
    logic [15:0] rxHecErr;
    logic [15:0] rxHecFixed;
  } tcs_evt_s;

  typedef struct packed {
    logic [NUM_CNT-1:0][CNT_W-1:0]     cnt;
    logic [NUM_CNT-1:0][LATCH_W-1:0]   snap;
    logic [NUM_CNT-1:0]                cntIrqEn;
    logic [NUM_LINK-1:0][15:0]         ovfStat;
    logic [NUM_LINK-1:0][15:0]         linkStat;
    logic [NUM_LINK-1:0][15:0]         linkEn;
    logic [15:0]                       ovfEn;
    logic [15:0]                       masterEn;
    logic [7:0]                        holdUp;
    logic [15:0]                       holdLo;
    logic [7:0]                        sel;
    logic                              latchEn;
    logic                              divSel;
    logic                              ready;
    logic                              pend;
    logic [2:0]                        pendOp;
    logic                              pendIrq;
    logic                              pendTrig;
    logic [12:0]                       divCnt;
    logic                              framePrev;
    logic [NUM_LINK-1:0]               lcdPrev;
    logic [15:0]                       rdData;
    logic                              irq_b;
  } tcs_state_s;

endpackage

// >>> hw/tcs_stats_counters_irq.sv
// Statistics counter bank with indirect access, latching mode and link interrupt hierarchy.
// Summary of operation
// - 144 counters of 24 bits, all cleared by hardware reset.
// - A counter adds one per event and wraps from all ones to zero.
// - Software can preload any counter to time an overflow.
// - Four counters per input port: cells, idle, unassigned, header errors.
// - Two counters per transmit link: all cells, idle or user cells.
// - Three counters per receive link, counting only while that port is enabled.
// - Header error counters skip corrected headers but include discarded cells.
// - Read command copies the selected count into holding registers until next read.
// - Write command loads the holding register value into the selected counter.
// - The interrupt transfer command sets or clears the selected counter's overflow enable.
// - An enabled counter that wraps raises its overflow request.
// - Latching copies all counters at once on pin or software trigger.
// - Pin trigger used per pulse or divided by 8000, as configured.
// - Latching mode uses 16-bit counters cleared after every latch.
// - Master status shows live per-link state of enabled link sources.
// - Interrupt pin is low while an enabled master status bit is set.
// - Accessing the master status register never changes the interrupt pin.
// - Link status bit 1 latches on delineation loss, bit 9 on recovery.
// - Link status bit 0 is live overflow of any enabled link counter or FIFO.
// - Latched link bits clear by writing zero; ones, bit 0 and reads do nothing.
// - A link enable bit of zero keeps that source from the master status.
// - The command register carries a ready bit for indirect transfers.
// - Overflow status layout: 12 FIFO, 11:8 input, 7 and 5 transmit, 3:1 receive.
`timescale 1ns/1ns
`default_nettype none

module tcs_stats_counters_irq (
  input  wire logic            mclk,
  input  wire logic            rst_b,
  input  wire logic            cs,
  input  wire logic            wrEn,
  input  wire logic            rdEn,
  input  wire logic [10:0]     addr,
  input  wire logic [15:0]     wrData,
  output logic      [15:0]     rdData,
  input  wire tcs_pkg::tcs_evt_s events,
  input  wire logic [15:0]     rxPortEn,
  input  wire logic [15:0]     rxFifoOvf,
  input  wire logic [15:0]     cellDelinLoss,
  input  wire logic            framePulse8khz,
  output logic                 irq_b
);

  tcs_pkg::tcs_state_s state_r;
  tcs_pkg::tcs_state_s state_nxt;

  logic [tcs_pkg::NUM_CNT-1:0]   evtVec;
  logic [tcs_pkg::NUM_CNT-1:0]   ovfHit;
  logic [tcs_pkg::CNT_W-1:0]     cntNext [tcs_pkg::NUM_CNT];
  logic [tcs_pkg::LATCH_W-1:0]   snapNext [tcs_pkg::NUM_CNT];
  logic [15:0]                   linkHit [tcs_pkg::NUM_LINK];
  logic [15:0]                   linkCntEn [tcs_pkg::NUM_LINK];
  logic [15:0]                   linkLive [tcs_pkg::NUM_LINK];
  logic [15:0]                   masterLive;
  logic                          doWrite;
  logic                          doRead;
  logic                          pinTrig;
  logic                          latchNow;
  logic                          selValid;
  logic [23:0]                   selVal;
  logic [23:0]                   holdVal;
  logic [10:0]                   ovfIdx;
  logic [10:0]                   lstIdx;
  logic [10:0]                   lenIdx;
  logic                          busWr;
  logic                          busRd;

  assign busWr    = cs && wrEn;
  assign busRd    = cs && rdEn;
  assign ovfIdx   = addr - tcs_pkg::ADDR_OVF_BASE;
  assign lstIdx   = addr - tcs_pkg::ADDR_LST_BASE;
  assign lenIdx   = addr - tcs_pkg::ADDR_LEN_BASE;
  assign holdVal  = {state_r.holdUp, state_r.holdLo};
  assign doWrite  = state_r.pend && (state_r.pendOp == tcs_pkg::OP_WRITE);
  assign doRead   = state_r.pend && (state_r.pendOp == tcs_pkg::OP_READ);
  assign selValid = state_r.sel < 8'(tcs_pkg::NUM_CNT);

  // Pin trigger is taken on the rising edge so a wide pulse latches only once.
  assign pinTrig  = framePulse8khz && !state_r.framePrev &&
                    (!state_r.divSel || state_r.divCnt == 13'(tcs_pkg::FRAME_DIV - 1));
  assign latchNow = state_r.latchEn && (pinTrig || (state_r.pend && state_r.pendTrig));

  // In latching mode the host sees the last snapshot, since the live count is cleared each latch.
  always_comb begin
    selVal = '0;
    if (selValid) begin
      if (state_r.latchEn) begin
        selVal = {8'h00, state_r.snap[state_r.sel]};
      end else begin
        selVal = state_r.cnt[state_r.sel];
      end
    end
  end

  genvar gl, gi;
  generate
    for (gl = 0; gl < tcs_pkg::NUM_LINK; gl++) begin : g_link
      localparam int IB = tcs_pkg::IN_BASE + gl * tcs_pkg::IN_PER;
      localparam int TB = tcs_pkg::TX_BASE + gl * tcs_pkg::TX_PER;
      localparam int RB = tcs_pkg::RX_BASE + gl * tcs_pkg::RX_PER;
      assign evtVec[IB + 0] = events.inCell[gl];
      assign evtVec[IB + 1] = events.inIdle[gl];
      assign evtVec[IB + 2] = events.inUnassigned[gl];
      assign evtVec[IB + 3] = events.inHecErr[gl] && !events.inHecFixed[gl];
      assign evtVec[TB + 0] = events.txCell[gl];
      assign evtVec[TB + 1] = events.txIdleUser[gl];
      assign evtVec[RB + 0] = rxPortEn[gl] && events.rxCell[gl];
      assign evtVec[RB + 1] = rxPortEn[gl] && events.rxIdleUser[gl];
      assign evtVec[RB + 2] = rxPortEn[gl] && events.rxHecErr[gl] && !events.rxHecFixed[gl];
      // Each used overflow status bit belongs to exactly one counter of the link, except FIFO bit 12.
      assign linkHit[gl]   = {3'b000, rxFifoOvf[gl], ovfHit[IB+3], ovfHit[IB+2], ovfHit[IB+1], ovfHit[IB],
                              ovfHit[TB+1], 1'b0, ovfHit[TB], 1'b0, ovfHit[RB+2], ovfHit[RB+1], ovfHit[RB],
                              1'b0};
      assign linkCntEn[gl] = {3'b000, 1'b1, state_r.cntIrqEn[IB+3], state_r.cntIrqEn[IB+2],
                              state_r.cntIrqEn[IB+1], state_r.cntIrqEn[IB], state_r.cntIrqEn[TB+1], 1'b0,
                              state_r.cntIrqEn[TB], 1'b0, state_r.cntIrqEn[RB+2], state_r.cntIrqEn[RB+1],
                              state_r.cntIrqEn[RB], 1'b0};
      assign linkLive[gl]  = {state_r.linkStat[gl][15:1],
                              |(state_r.ovfStat[gl] & state_r.ovfEn & linkCntEn[gl])};
      assign masterLive[gl] = |(linkLive[gl] & state_r.linkEn[gl]);
    end

    for (gi = 0; gi < tcs_pkg::NUM_CNT; gi++) begin : g_cnt
      logic atMax;
      logic loadHit;
      assign atMax   = state_r.cnt[gi] == (state_r.latchEn ? tcs_pkg::CNT_MAX_LATCH : tcs_pkg::CNT_MAX_FULL);
      assign loadHit = doWrite && (state_r.sel == 8'(gi));
      assign cntNext[gi] = loadHit  ? holdVal :
                           latchNow ? '0 :
                           !evtVec[gi] ? state_r.cnt[gi] :
                           atMax ? '0 : state_r.cnt[gi] + 24'h000001;
      assign snapNext[gi] = latchNow ? state_r.cnt[gi][15:0] : state_r.snap[gi];
      assign ovfHit[gi]   = evtVec[gi] && atMax && !loadHit && !latchNow && state_r.cntIrqEn[gi];
    end
  endgenerate

  always_comb begin
    state_nxt = state_r;
    for (int i = 0; i < tcs_pkg::NUM_CNT; i++) begin
      state_nxt.cnt[i]  = cntNext[i];
      state_nxt.snap[i] = snapNext[i];
    end
    state_nxt.framePrev = framePulse8khz;
    state_nxt.lcdPrev   = cellDelinLoss;
    if (framePulse8khz && !state_r.framePrev) begin
      state_nxt.divCnt = (state_r.divCnt == 13'(tcs_pkg::FRAME_DIV - 1)) ? '0 : state_r.divCnt + 13'h0001;
    end

    // Second cycle of a command: perform it and raise ready.
    if (state_r.pend) begin
      state_nxt.pend  = 1'b0;
      state_nxt.ready = 1'b1;
      if (doRead) begin
        state_nxt.holdUp = selVal[23:16];
        state_nxt.holdLo = selVal[15:0];
      end
      if (state_r.pendOp == tcs_pkg::OP_IRQ && selValid) begin
        state_nxt.cntIrqEn[state_r.sel] = state_r.pendIrq;
      end
    end

    state_nxt.rdData = '0;
    if (busRd) begin
      if (addr == tcs_pkg::ADDR_CMD) begin
        state_nxt.rdData = {8'h00, state_r.ready, state_r.latchEn, state_r.divSel, 5'h00};
      end else if (ovfIdx < 11'(tcs_pkg::NUM_LINK)) begin
        state_nxt.rdData = state_r.ovfStat[ovfIdx[3:0]];
      end else if (addr == tcs_pkg::ADDR_HOLD_UP) begin
        state_nxt.rdData = {8'h00, state_r.holdUp};
      end else if (addr == tcs_pkg::ADDR_HOLD_LO) begin
        state_nxt.rdData = state_r.holdLo;
      end else if (addr == tcs_pkg::ADDR_SEL) begin
        state_nxt.rdData = {8'h00, state_r.sel};
      end else if (addr == tcs_pkg::ADDR_MEN) begin
        state_nxt.rdData = state_r.masterEn;
      end else if (addr == tcs_pkg::ADDR_OVF_EN) begin
        state_nxt.rdData = state_r.ovfEn;
      end else if (lstIdx < 11'(tcs_pkg::NUM_LINK)) begin
        state_nxt.rdData = linkLive[lstIdx[3:0]];
      end else if (lenIdx < 11'(tcs_pkg::NUM_LINK)) begin
        state_nxt.rdData = state_r.linkEn[lenIdx[3:0]];
      end else if (addr == tcs_pkg::ADDR_MST) begin
        state_nxt.rdData = masterLive;
      end
    end

    if (busWr) begin
      if (addr == tcs_pkg::ADDR_CMD) begin
        state_nxt.pend     = 1'b1;
        state_nxt.ready    = 1'b0;
        state_nxt.pendOp   = wrData[2:0];
        state_nxt.pendIrq  = wrData[tcs_pkg::CMD_IRQ_BIT];
        state_nxt.pendTrig = (wrData[2:0] == tcs_pkg::OP_CONFIG) && wrData[tcs_pkg::CMD_TRIG_BIT];
        state_nxt.latchEn  = wrData[tcs_pkg::CMD_LATCH_BIT];
        if (wrData[2:0] == tcs_pkg::OP_CONFIG) begin
          state_nxt.divSel = wrData[tcs_pkg::CMD_DIV_BIT];
        end
      end else if (ovfIdx < 11'(tcs_pkg::NUM_LINK)) begin
        state_nxt.ovfStat[ovfIdx[3:0]] = state_r.ovfStat[ovfIdx[3:0]] & wrData;
      end else if (addr == tcs_pkg::ADDR_HOLD_UP) begin
        state_nxt.holdUp = wrData[7:0];
      end else if (addr == tcs_pkg::ADDR_HOLD_LO) begin
        state_nxt.holdLo = wrData;
      end else if (addr == tcs_pkg::ADDR_SEL) begin
        state_nxt.sel = wrData[7:0];
      end else if (addr == tcs_pkg::ADDR_MEN) begin
        state_nxt.masterEn = wrData;
      end else if (addr == tcs_pkg::ADDR_OVF_EN) begin
        state_nxt.ovfEn = wrData;
      end else if (lstIdx < 11'(tcs_pkg::NUM_LINK)) begin
        state_nxt.linkStat[lstIdx[3:0]] = state_r.linkStat[lstIdx[3:0]] &
                                          (wrData | ~tcs_pkg::LST_LATCH_MASK);
      end else if (lenIdx < 11'(tcs_pkg::NUM_LINK)) begin
        state_nxt.linkEn[lenIdx[3:0]] = wrData;
      end
    end

    // Hardware sets are applied after software clears so a coincident event is kept.
    for (int l = 0; l < tcs_pkg::NUM_LINK; l++) begin
      state_nxt.ovfStat[l] = state_nxt.ovfStat[l] | (linkHit[l] & tcs_pkg::OVF_USED_MASK);
      if (cellDelinLoss[l] && !state_r.lcdPrev[l]) begin
        state_nxt.linkStat[l][tcs_pkg::LCD_ON_BIT] = 1'b1;
      end
      if (!cellDelinLoss[l] && state_r.lcdPrev[l]) begin
        state_nxt.linkStat[l][tcs_pkg::LCD_OFF_BIT] = 1'b1;
      end
    end

    // The pin follows live status only, so master status accesses cannot move it.
    state_nxt.irq_b = !(|(masterLive & state_r.masterEn));
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r       <= '0;
      state_r.ready <= 1'b1;
      state_r.irq_b <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdData = state_r.rdData;
  assign irq_b  = state_r.irq_b;

  property p_ready_cycle;
    @(posedge mclk) disable iff (!rst_b)
      (busWr && addr == tcs_pkg::ADDR_CMD) |=> !state_r.ready ##1 state_r.ready;
  endproperty
  a_ready_cycle: assert property (p_ready_cycle) else $error("ready did not drop then rise after a command");

  property p_read_copy;
    @(posedge mclk) disable iff (!rst_b)
      (doRead && !busWr) |=> {state_r.holdUp, state_r.holdLo} == $past(selVal);
  endproperty
  a_read_copy: assert property (p_read_copy) else $error("holding registers do not match the selected count");

  property p_count_inc;
    @(posedge mclk) disable iff (!rst_b)
      (evtVec[12] && !g_cnt[12].atMax && !g_cnt[12].loadHit && !latchNow)
        |=> state_r.cnt[12] == $past(state_r.cnt[12]) + 24'h000001;
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("counter did not add one on its event");

  property p_count_wrap;
    @(posedge mclk) disable iff (!rst_b)
      (evtVec[12] && g_cnt[12].atMax && !g_cnt[12].loadHit && !latchNow) |=> state_r.cnt[12] == 24'h000000;
  endproperty
  a_count_wrap: assert property (p_count_wrap) else $error("counter did not wrap to zero");

  property p_preload;
    @(posedge mclk) disable iff (!rst_b)
      (doWrite && state_r.sel == 8'h0c) |=> state_r.cnt[12] == $past(holdVal);
  endproperty
  a_preload: assert property (p_preload) else $error("preload value not taken by counter");

  property p_latch_clear;
    @(posedge mclk) disable iff (!rst_b)
      (latchNow && !doWrite) |=> state_r.cnt[20] == 24'h000000 && state_r.snap[20] == $past(state_r.cnt[20][15:0]);
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch did not snapshot and clear the counter");

  property p_ovf_flag;
    @(posedge mclk) disable iff (!rst_b)
      ovfHit[12] |=> state_r.ovfStat[3][8];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("enabled counter wrap did not set its overflow bit");

  property p_irq_pin;
    @(posedge mclk) disable iff (!rst_b)
      (|(masterLive & state_r.masterEn)) |=> !irq_b;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not low with an enabled master source");

  property p_lcd_latch;
    @(posedge mclk) disable iff (!rst_b)
      (cellDelinLoss[2] && !state_r.lcdPrev[2]) |=> state_r.linkStat[2][tcs_pkg::LCD_ON_BIT];
  endproperty
  a_lcd_latch: assert property (p_lcd_latch) else $error("delineation loss not latched in link status");

  property p_link_mask;
    @(posedge mclk) disable iff (!rst_b)
      (state_r.linkEn[3] == 16'h0000) |-> !masterLive[3];
  endproperty
  a_link_mask: assert property (p_link_mask) else $error("disabled link still reaches master status");

endmodule // tcs_stats_counters_irq

`default_nettype wire

// >>> verification/tcs_host_model.sv
// Behavioural host processor that drives the register bus of the counter block.
`timescale 1ns/1ns
`default_nettype none

module tcs_host_model (
  input  wire logic        mclk,
  output var  logic        cs,
  output var  logic        wrEn,
  output var  logic        rdEn,
  output var  logic [10:0] addr,
  output var  logic [15:0] wrData,
  input  wire logic [15:0] rdData
);
  logic        latchOn = 1'b0;
  logic [15:0] stat;

  initial begin
    {cs, wrEn, rdEn, addr, wrData} = '0;
  end

  // The request is held until the next rising edge, where the block takes it.
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge mclk);
    #1 {cs, wrEn, addr, wrData} = {2'b11, a, d};
    @(posedge mclk);
    #1 {cs, wrEn} = 2'b00;
  endtask

  task automatic rd(input logic [10:0] a, output logic [15:0] d);
    @(posedge mclk);
    #1 {cs, rdEn, addr} = {2'b11, a};
    @(posedge mclk);
    #1 {cs, rdEn} = 2'b00;
    d = rdData;
  endtask

  // Every command write also rewrites the latching enable, so it is carried along.
  task automatic cmd(input logic [5:0] low);
    int n;
    n = 0;
    wr(tcs_pkg::ADDR_CMD, {8'h00, 1'b0, latchOn, low});
    do begin
      rd(tcs_pkg::ADDR_CMD, stat);
      n++;
    end while (!stat[7] && n < 8);
  endtask

  task automatic rdCnt(input logic [7:0] sel, output logic [23:0] v);
    logic [15:0] up;
    logic [15:0] lo;
    wr(tcs_pkg::ADDR_SEL, {8'h00, sel});
    cmd(6'h05);
    rd(tcs_pkg::ADDR_HOLD_UP, up);
    rd(tcs_pkg::ADDR_HOLD_LO, lo);
    v = {up[7:0], lo};
  endtask

  // Preloads are only issued while latching is off.
  task automatic wrCnt(input logic [7:0] sel, input logic [23:0] v);
    if (!latchOn) begin
      wr(tcs_pkg::ADDR_HOLD_UP, {8'h00, v[23:16]});
      wr(tcs_pkg::ADDR_HOLD_LO, v[15:0]);
      wr(tcs_pkg::ADDR_SEL, {8'h00, sel});
      cmd(6'h01);
    end
  endtask

  task automatic irqEn(input logic [7:0] sel, input logic en);
    wr(tcs_pkg::ADDR_SEL, {8'h00, sel});
    cmd({2'b00, en, 3'b010});
  endtask

  task automatic cfg(input logic on, input logic [5:0] low);
    latchOn = on;
    cmd(low);
  endtask
endmodule // tcs_host_model

`default_nettype wire

// >>> verification/tb_tcs_stats_counters_irq.sv
// Self-checking testbench for the statistics counter and interrupt block.
`timescale 1ns/1ns
`default_nettype none

module tb_tcs_stats_counters_irq;
  logic              mclk;
  logic              rst_b;
  logic              cs;
  logic              wrEn;
  logic              rdEn;
  logic [10:0]       addr;
  logic [15:0]       wrData;
  logic [15:0]       rdData;
  tcs_pkg::tcs_evt_s ev;
  logic [15:0]       rxPortEn;
  logic [15:0]       rxFifoOvf;
  logic [15:0]       delinLoss;
  logic              frame;
  logic              irqB;
  logic [23:0]       v;
  logic [15:0]       st;
  int                failures = 0;
  int                n_compared = 0;
  int                cyc = 0;
  int                fld[6] = '{0, 1, 2, 3, 5, 6};
  logic [7:0]        idx[6] = '{8'd20, 8'd21, 8'd22, 8'd23, 8'd74, 8'd75};

  tcs_stats_counters_irq dut_u (.mclk(mclk), .rst_b(rst_b), .cs(cs), .wrEn(wrEn), .rdEn(rdEn), .addr(addr),
    .wrData(wrData), .rdData(rdData), .events(ev), .rxPortEn(rxPortEn), .rxFifoOvf(rxFifoOvf),
    .cellDelinLoss(delinLoss), .framePulse8khz(frame), .irq_b(irqB));
  tcs_host_model host_u (.mclk(mclk), .cs(cs), .wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wrData(wrData),
    .rdData(rdData));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Field f of the event struct sits at bits (10-f)*16 upward; one pulse per event.
  task automatic evp(input int f, input int l, input int n);
    repeat (n) begin
      @(posedge mclk);
      #1 ev[(10 - f) * 16 + l] = 1'b1;
      @(posedge mclk);
      #1 ev = '0;
    end
  endtask

  task automatic fp(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1 frame = 1'b1;
      @(posedge mclk);
      #1 frame = 1'b0;
    end
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // The divided latch scenario needs about 16000 cycles, so the ceiling leaves ample margin.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    {rst_b, ev, rxPortEn, rxFifoOvf, delinLoss, frame} = '0;
    repeat (10) @(posedge mclk);
    #1 rst_b = 1'b1;
    host_u.rd(tcs_pkg::ADDR_CMD, st);
    chk("command reset", {8'h0, st}, 24'h80);
    host_u.rdCnt(8'd12, v);
    chk("counter reset", v, 24'h0);
    host_u.wrCnt(8'd12, 24'hfffffe);
    host_u.rdCnt(8'd12, v);
    chk("preload", v, 24'hfffffe);
    host_u.irqEn(8'd12, 1'b1);
    host_u.wr(tcs_pkg::ADDR_OVF_EN, 16'h0100);
    host_u.wr(tcs_pkg::ADDR_LEN_BASE + 11'h3, 16'h0001);
    host_u.wr(tcs_pkg::ADDR_MEN, 16'h0008);
    evp(0, 3, 1);
    host_u.rd(tcs_pkg::ADDR_OVF_BASE + 11'h3, st);
    chk("no overflow", {8'h0, st}, 24'h0);
    evp(0, 3, 1);
    repeat (3) @(posedge mclk);
    host_u.rd(tcs_pkg::ADDR_OVF_BASE + 11'h3, st);
    chk("overflow bit", {8'h0, st}, 24'h100);
    host_u.rd(tcs_pkg::ADDR_LST_BASE + 11'h3, st);
    chk("link bit0", {8'h0, st}, 24'h1);
    host_u.rd(tcs_pkg::ADDR_MST, st);
    chk("master", {8'h0, st}, 24'h8);
    host_u.wr(tcs_pkg::ADDR_MST, 16'h0000);
    chk("irq low", {23'h0, irqB}, 24'h0);
    host_u.rdCnt(8'd12, v);
    chk("wrap", v, 24'h0);
    host_u.wr(tcs_pkg::ADDR_MEN, 16'h0000);
    repeat (2) @(posedge mclk);
    #1;
    chk("irq masked", {23'h0, irqB}, 24'h1);
    host_u.wr(tcs_pkg::ADDR_MEN, 16'h0008);
    host_u.wr(tcs_pkg::ADDR_LEN_BASE + 11'h3, 16'h0000);
    host_u.rd(tcs_pkg::ADDR_MST, st);
    chk("link disabled", {8'h0, st}, 24'h0);
    host_u.wr(tcs_pkg::ADDR_LEN_BASE + 11'h3, 16'h0001);
    host_u.irqEn(8'd12, 1'b0);
    host_u.rd(tcs_pkg::ADDR_LST_BASE + 11'h3, st);
    chk("counter masked", {8'h0, st}, 24'h0);
    host_u.irqEn(8'd12, 1'b1);
    host_u.wr(tcs_pkg::ADDR_OVF_BASE + 11'h3, 16'h0000);
    repeat (2) @(posedge mclk);
    #1;
    chk("overflow cleared", {23'h0, irqB}, 24'h1);
    delinLoss[2] = 1'b1;
    repeat (2) @(posedge mclk);
    host_u.rd(tcs_pkg::ADDR_LST_BASE + 11'h2, st);
    chk("loss latched", {8'h0, st}, 24'h2);
    delinLoss[2] = 1'b0;
    repeat (2) @(posedge mclk);
    host_u.wr(tcs_pkg::ADDR_LST_BASE + 11'h2, 16'hffff);
    host_u.rd(tcs_pkg::ADDR_LST_BASE + 11'h2, st);
    chk("recovery latched", {8'h0, st}, 24'h202);
    host_u.wr(tcs_pkg::ADDR_LST_BASE + 11'h2, 16'hfdff);
    host_u.rd(tcs_pkg::ADDR_LST_BASE + 11'h2, st);
    chk("zero clears", {8'h0, st}, 24'h2);
    @(posedge mclk);
    #1 rxFifoOvf[4] = 1'b1;
    @(posedge mclk);
    #1 rxFifoOvf = '0;
    host_u.rd(tcs_pkg::ADDR_OVF_BASE + 11'h4, st);
    chk("fifo overflow", {8'h0, st}, 24'h1000);
    evp(7, 0, 1);
    rxPortEn[0] = 1'b1;
    evp(7, 0, 2);
    @(posedge mclk);
    #1 {ev.rxHecErr[0], ev.rxHecFixed[0]} = 2'b11;
    @(posedge mclk);
    #1 ev = '0;
    evp(9, 0, 1);
    host_u.rdCnt(8'd96, v);
    chk("rx enabled", v, 24'h2);
    host_u.rdCnt(8'd98, v);
    chk("rx header err", v, 24'h1);
    for (int i = 0; i < 6; i++) begin
      evp(fld[i], 5, i + 1);
      host_u.rdCnt(idx[i], v);
      chk("port map", v, 24'(i + 1));
    end
    host_u.cfg(1'b1, 6'h00);
    evp(0, 5, 3);
    host_u.cfg(1'b1, 6'h10);
    host_u.rdCnt(8'd20, v);
    chk("soft latch", v, 24'h4);
    evp(0, 5, 2);
    fp(1);
    repeat (2) @(posedge mclk);
    host_u.rdCnt(8'd20, v);
    chk("pin latch", v, 24'h2);
    host_u.cfg(1'b1, 6'h20);
    evp(0, 5, 1);
    fp(8000);
    repeat (2) @(posedge mclk);
    host_u.rdCnt(8'd20, v);
    chk("divided latch", v, 24'h1);
    stop_test();
  end
endmodule // tb_tcs_stats_counters_irq

`default_nettype wire
